// ### src/l1_data_cache_controller.sv
// level-one data cache controller with apb control and test registers
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module l1_data_cache_controller #(
  parameter int SET_W  = 8,
  parameter int WORD_W = 3
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        core_req_valid,
  input  wire logic [1:0]  core_req_kind,
  input  wire logic [31:0] core_req_addr,
  input  wire logic [31:0] core_req_wdata,
  input  wire logic [3:0]  core_req_be,
  input  wire logic        core_req_cacheable,
  input  wire logic [1:0]  core_req_wmode,
  input  wire logic        core_abort,
  output logic             core_req_ready,
  output logic             core_rsp_valid,
  output logic      [31:0] core_rsp_rdata,
  output logic             sys_req_valid,
  output logic             sys_req_write,
  output logic             sys_req_burst,
  output logic      [31:0] sys_req_addr,
  output logic      [31:0] sys_req_wdata,
  output logic      [3:0]  sys_req_be,
  input  wire logic        sys_req_ready,
  input  wire logic        sys_rdata_valid,
  input  wire logic [31:0] sys_rdata
);
  localparam int TAG_LO = 2 + WORD_W + SET_W;
  localparam int TAG_W  = 32 - TAG_LO;
  localparam int LW     = 1 << WORD_W;
  localparam int NL     = 4 << SET_W;
  localparam int NS2    = 2 << SET_W;
  localparam logic [WORD_W-1:0] LAST_WD = WORD_W'(LW - 1);

  typedef struct packed {
    l1dc_pkg::ctl_state_t st;
    logic                 ready;
    logic                 rsp_valid;
    logic [31:0]          rsp_data;
    logic                 sys_valid;
    logic                 sys_write;
    logic                 sys_burst;
    logic [31:0]          sys_addr;
    logic [31:0]          sys_wdata;
    logic [3:0]           sys_be;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    logic [1:0]           dmc;
    logic                 cache_bank_steer_select;
    logic                 dpe;
    logic [31:0]          tst_cmd;
    logic [31:0]          tst_data;
    logic                 tst_pend;
    logic [1:0]           q_kind;
    logic [1:0]           q_mode;
    logic                 q_cach;
    logic [31:0]          q_addr;
    logic [31:0]          q_wdata;
    logic [3:0]           q_be;
    logic                 q_bank;
    logic                 q_way;
    logic [TAG_W-1:0]     q_vtag;
    logic [LW-1:0][31:0]  vbuf;
    logic [WORD_W-1:0]    vcnt;
    logic [2:0]           stall_cnt;
    logic                 f_busy;
    logic                 f_drain;
    logic                 f_st;
    logic                 f_dirty;
    logic                 f_bank;
    logic                 f_way;
    logic [SET_W-1:0]     f_set;
    logic [TAG_W-1:0]     f_tag;
    logic [WORD_W-1:0]    f_crit;
    logic [WORD_W-1:0]    f_cnt;
    logic [31:0]          f_wdata;
    logic [3:0]           f_be;
    logic [LW-1:0][31:0]  lfb;
    logic                 sb_v;
    logic                 sb_bank;
    logic                 sb_way;
    logic [SET_W-1:0]     sb_set;
    logic [WORD_W-1:0]    sb_wd;
    logic [31:0]          sb_data;
    logic [3:0]           sb_be;
    logic [NL-1:0]        val;
    logic [NL-1:0]        dirty;
    logic [NS2-1:0]       lru;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // arrays have no reset; valid bits reset instead
  logic [TAG_W-1:0] tag_mem  [NL];
  logic [31:0]      data_mem [NL*LW];

  function automatic logic [SET_W+1:0] lidx(input logic b, input logic w,
                                            input logic [SET_W-1:0] st);
    return {b, w, st};
  endfunction

  function automatic logic [SET_W+WORD_W+1:0] didx(input logic b, input logic w,
                                                   input logic [SET_W-1:0] st,
                                                   input logic [WORD_W-1:0] wd);
    return {b, w, st, wd};
  endfunction

  // returns 0 for bank A, 1 for bank B
  function automatic logic bank_of(input logic [31:0] a, input logic [1:0] dmc,
                                   input logic cache_bank_steer_select);
    if (dmc == l1dc_pkg::DMC_BOTH) begin
      return cache_bank_steer_select ? ~a[l1dc_pkg::STEER_HI_BIT] : ~a[l1dc_pkg::STEER_LO_BIT];
    end
    return 1'b0;
  endfunction

  // sub-bank and half-bank bits are the top set bits
  function automatic logic collide(input logic b1, input logic [SET_W-1:0] s1,
                                   input logic b2, input logic [SET_W-1:0] s2);
    return (b1 == b2) &&
      (s1[SET_W-1 -: l1dc_pkg::COLL_BITS] == s2[SET_W-1 -: l1dc_pkg::COLL_BITS]);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic                take;
  logic [SET_W-1:0]    lk_set;
  logic [WORD_W-1:0]   lk_wd;
  logic [TAG_W-1:0]    lk_tag;
  logic [1:0]          hit_w;
  logic                hway;
  logic                vway;
  logic [LW-1:0][31:0] vline;
  logic                t_bank;
  logic                t_way;
  logic [SET_W-1:0]    t_set;
  logic [WORD_W-1:0]   t_wd;
  logic                g_tst;
  logic                g_sb;
  logic                g_fill;
  logic                fill_done;
  logic [31:0]         fill_word;
  logic [WORD_W-1:0]   f_slot;
  logic [SET_W+1:0]    v_idx;
  logic [SET_W+1:0]    t_idx;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    take = core_req_valid & s_r.ready;
    lk_set = s_r.q_addr[2+WORD_W +: SET_W];
    lk_wd = s_r.q_addr[2 +: WORD_W];
    lk_tag = s_r.q_addr[31:TAG_LO];
    for (int i = 0; i < 2; i++) begin
      hit_w[i] = s_r.q_cach && s_r.val[lidx(s_r.q_bank, i[0], lk_set)] &&
                 (tag_mem[lidx(s_r.q_bank, i[0], lk_set)] == lk_tag);
    end
    hway = hit_w[1];
    // invalid way first, else least recently used
    if (!s_r.val[lidx(s_r.q_bank, 1'b0, lk_set)]) begin
      vway = 1'b0;
    end else if (!s_r.val[lidx(s_r.q_bank, 1'b1, lk_set)]) begin
      vway = 1'b1;
    end else begin
      vway = s_r.lru[{s_r.q_bank, lk_set}];
    end
    v_idx = lidx(s_r.q_bank, vway, lk_set);
    for (int i = 0; i < LW; i++) begin
      vline[i] = data_mem[didx(s_r.q_bank, vway, lk_set, i[WORD_W-1:0])];
    end
    t_bank = s_r.tst_cmd[l1dc_pkg::TC_BANK];
    t_way = s_r.tst_cmd[l1dc_pkg::TC_WAY];
    t_set = s_r.tst_cmd[l1dc_pkg::TC_SET_LO +: SET_W];
    t_wd = s_r.tst_cmd[l1dc_pkg::TC_WORD_LO +: WORD_W];
    t_idx = lidx(t_bank, t_way, t_set);
    g_tst = s_r.tst_pend;
    g_sb = s_r.sb_v & ~(g_tst & collide(t_bank, t_set, s_r.sb_bank, s_r.sb_set));
    g_fill = s_r.f_drain & ~(g_tst & collide(t_bank, t_set, s_r.f_bank, s_r.f_set)) &
             ~(g_sb & collide(s_r.sb_bank, s_r.sb_set, s_r.f_bank, s_r.f_set));
    fill_done = g_fill & (s_r.f_cnt == LAST_WD);
    fill_word = s_r.lfb[s_r.f_cnt];
    if (s_r.f_st && (s_r.f_cnt == s_r.f_crit)) begin
      fill_word = merge_be(s_r.lfb[s_r.f_cnt], s_r.f_wdata, s_r.f_be);
    end
    f_slot = WORD_W'(s_r.f_crit + s_r.f_cnt);

    // apb: decode in setup, answer in the access phase
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        l1dc_pkg::OFS_CTRL: begin
          s_nxt.prdata[l1dc_pkg::CTRL_DMC_LO +: 2] = s_r.dmc;
          s_nxt.prdata[l1dc_pkg::CTRL_CACHE_BANK_STEER_SELECT] = s_r.cache_bank_steer_select;
          s_nxt.prdata[l1dc_pkg::CTRL_DPE] = s_r.dpe;
        end
        l1dc_pkg::OFS_TCMD:   s_nxt.prdata = s_r.tst_cmd;
        l1dc_pkg::OFS_TDATA:  s_nxt.prdata = s_r.tst_data;
        l1dc_pkg::OFS_STATUS: s_nxt.prdata = {26'h0, s_r.sb_v, s_r.f_busy, 1'b0, s_r.st};
        default:              s_nxt.pslverr = 1'b1;
      endcase
    end else if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
      unique case (paddr)
        l1dc_pkg::OFS_CTRL: begin
          s_nxt.dmc = pwdata[l1dc_pkg::CTRL_DMC_LO +: 2];
          s_nxt.cache_bank_steer_select = pwdata[l1dc_pkg::CTRL_CACHE_BANK_STEER_SELECT];
          s_nxt.dpe = pwdata[l1dc_pkg::CTRL_DPE];
        end
        l1dc_pkg::OFS_TCMD: begin
          s_nxt.tst_cmd = pwdata;
          s_nxt.tst_pend = 1'b1;
        end
        l1dc_pkg::OFS_TDATA: s_nxt.tst_data = pwdata;
        default: ;
      endcase
    end

    // test port first in the arrays
    if (g_tst) begin
      s_nxt.tst_pend = 1'b0;
      if (s_r.tst_cmd[l1dc_pkg::TC_TAG]) begin
        if (s_r.tst_cmd[l1dc_pkg::TC_WR]) begin
          s_nxt.val[t_idx] = s_r.tst_data[l1dc_pkg::TD_VALID];
          s_nxt.dirty[t_idx] = s_r.tst_data[l1dc_pkg::TD_DIRTY];
        end else begin
          s_nxt.tst_data = '0;
          s_nxt.tst_data[31:TAG_LO] = tag_mem[t_idx];
          s_nxt.tst_data[l1dc_pkg::TD_VALID] = s_r.val[t_idx];
          s_nxt.tst_data[l1dc_pkg::TD_DIRTY] = s_r.dirty[t_idx];
        end
      end else if (!s_r.tst_cmd[l1dc_pkg::TC_WR]) begin
        s_nxt.tst_data = data_mem[didx(t_bank, t_way, t_set, t_wd)];
      end
    end
    if (g_sb) begin
      s_nxt.sb_v = 1'b0;
    end

    // line fill: collect, then drain into the arrays
    if (sys_rdata_valid && s_r.f_busy && !s_r.f_drain) begin
      s_nxt.lfb[f_slot] = sys_rdata;
      s_nxt.f_cnt = s_r.f_cnt + 1'b1;
      if (s_r.f_cnt == LAST_WD) begin
        s_nxt.f_drain = 1'b1;
      end
    end else if (g_fill) begin
      s_nxt.f_cnt = s_r.f_cnt + 1'b1;
      if (fill_done) begin
        s_nxt.f_busy = 1'b0;
        s_nxt.f_drain = 1'b0;
        s_nxt.val[lidx(s_r.f_bank, s_r.f_way, s_r.f_set)] = 1'b1;
        s_nxt.dirty[lidx(s_r.f_bank, s_r.f_way, s_r.f_set)] = s_r.f_dirty;
        s_nxt.lru[{s_r.f_bank, s_r.f_set}] = ~s_r.f_way;
      end
    end

    unique case (s_r.st)
      l1dc_pkg::S_IDLE: begin
        if (take) begin
          s_nxt.q_kind = core_req_kind;
          s_nxt.q_mode = core_req_wmode;
          s_nxt.q_cach = core_req_cacheable & s_r.dpe & s_r.dmc[1];
          s_nxt.q_addr = core_req_addr;
          s_nxt.q_wdata = core_req_wdata;
          s_nxt.q_be = core_req_be;
          s_nxt.q_bank = bank_of(core_req_addr, s_r.dmc, s_r.cache_bank_steer_select);
          s_nxt.st = l1dc_pkg::S_LOOK;
        end
      end
      l1dc_pkg::S_LOOK: begin
        if (s_r.sb_v) begin
          s_nxt.st = l1dc_pkg::S_LOOK;
        end else if (!s_r.q_cach) begin
          if (s_r.q_kind == l1dc_pkg::KIND_PREF) begin
            s_nxt.st = l1dc_pkg::S_IDLE;
          end else if (!(s_r.q_kind == l1dc_pkg::KIND_LOAD && s_r.f_busy)) begin
            s_nxt.st = l1dc_pkg::S_SYS;
          end
        end else if (|hit_w) begin
          s_nxt.lru[{s_r.q_bank, lk_set}] = ~hway;
          s_nxt.st = l1dc_pkg::S_IDLE;
          if (s_r.q_kind == l1dc_pkg::KIND_LOAD) begin
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_data = data_mem[didx(s_r.q_bank, hway, lk_set, lk_wd)];
          end else if (s_r.q_kind == l1dc_pkg::KIND_STORE) begin
            s_nxt.sb_v = 1'b1;
            s_nxt.sb_bank = s_r.q_bank;
            s_nxt.sb_way = hway;
            s_nxt.sb_set = lk_set;
            s_nxt.sb_wd = lk_wd;
            s_nxt.sb_data = s_r.q_wdata;
            s_nxt.sb_be = s_r.q_be;
            if (s_r.q_mode == l1dc_pkg::WM_WB) begin
              s_nxt.dirty[lidx(s_r.q_bank, hway, lk_set)] = 1'b1;
            end else begin
              s_nxt.st = l1dc_pkg::S_SYS;
            end
          end
        end else if (s_r.q_kind == l1dc_pkg::KIND_STORE && s_r.q_mode == l1dc_pkg::WM_WT_RO) begin
          s_nxt.st = l1dc_pkg::S_SYS;
        end else if (!s_r.f_busy) begin
          s_nxt.q_way = vway;
          s_nxt.q_vtag = tag_mem[v_idx];
          s_nxt.vbuf = vline;
          s_nxt.vcnt = '0;
          s_nxt.val[v_idx] = 1'b0;
          s_nxt.dirty[v_idx] = 1'b0;
          if (s_r.val[v_idx] && s_r.dirty[v_idx]) begin
            s_nxt.st = l1dc_pkg::S_CB;
          end else begin
            s_nxt.st = l1dc_pkg::S_FREQ;
          end
        end
      end
      l1dc_pkg::S_CB: begin
        if (sys_req_ready) begin
          s_nxt.vcnt = s_r.vcnt + 1'b1;
          if (s_r.vcnt == LAST_WD) begin
            s_nxt.st = l1dc_pkg::S_FREQ;
          end
        end
      end
      l1dc_pkg::S_FREQ: begin
        if (sys_req_ready) begin
          s_nxt.f_busy = 1'b1;
          s_nxt.f_bank = s_r.q_bank;
          s_nxt.f_way = s_r.q_way;
          s_nxt.f_set = lk_set;
          s_nxt.f_tag = lk_tag;
          s_nxt.f_crit = lk_wd;
          s_nxt.f_cnt = '0;
          s_nxt.f_st = s_r.q_kind == l1dc_pkg::KIND_STORE;
          s_nxt.f_wdata = s_r.q_wdata;
          s_nxt.f_be = s_r.q_be;
          s_nxt.f_dirty = s_nxt.f_st && (s_r.q_mode == l1dc_pkg::WM_WB);
          s_nxt.stall_cnt = 3'h1;
          s_nxt.st = (s_r.q_kind == l1dc_pkg::KIND_LOAD) ? l1dc_pkg::S_WAIT : l1dc_pkg::S_STALL;
        end
      end
      l1dc_pkg::S_WAIT: begin
        if (sys_rdata_valid && s_r.f_cnt == '0) begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = sys_rdata;
          s_nxt.st = l1dc_pkg::S_IDLE;
        end else if (core_abort) begin // fill runs on
          s_nxt.st = l1dc_pkg::S_IDLE;
        end
      end
      l1dc_pkg::S_STALL: begin
        s_nxt.stall_cnt = s_r.stall_cnt + 3'h1;
        if (s_r.stall_cnt == l1dc_pkg::MISS_STALL_CYC) begin
          // write-through allocating stores still go out after the stall
          if (s_r.q_kind == l1dc_pkg::KIND_STORE && s_r.q_mode != l1dc_pkg::WM_WB) begin
            s_nxt.st = l1dc_pkg::S_SYS;
          end else begin
            s_nxt.st = l1dc_pkg::S_IDLE;
          end
        end
      end
      l1dc_pkg::S_SYS: begin
        if (sys_req_ready) begin
          s_nxt.st = s_r.sys_write ? l1dc_pkg::S_IDLE : l1dc_pkg::S_NCW;
        end
      end
      l1dc_pkg::S_NCW: begin
        if (sys_rdata_valid) begin
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_data = sys_rdata;
          s_nxt.st = l1dc_pkg::S_IDLE;
        end
      end
    endcase

    // system request outputs follow the next state
    s_nxt.sys_valid = (s_nxt.st == l1dc_pkg::S_CB) || (s_nxt.st == l1dc_pkg::S_FREQ) ||
                      (s_nxt.st == l1dc_pkg::S_SYS);
    s_nxt.sys_write = (s_nxt.st == l1dc_pkg::S_CB) ||
                      ((s_nxt.st == l1dc_pkg::S_SYS) && (s_nxt.q_kind == l1dc_pkg::KIND_STORE));
    s_nxt.sys_burst = s_nxt.st == l1dc_pkg::S_FREQ;
    if (s_nxt.st == l1dc_pkg::S_CB) begin
      s_nxt.sys_addr = {s_nxt.q_vtag, s_nxt.q_addr[2+WORD_W +: SET_W], s_nxt.vcnt, 2'h0};
      s_nxt.sys_wdata = s_nxt.vbuf[s_nxt.vcnt];
      s_nxt.sys_be = 4'hf;
    end else begin
      s_nxt.sys_addr = {s_nxt.q_addr[31:2], 2'h0};
      s_nxt.sys_wdata = s_nxt.q_wdata;
      s_nxt.sys_be = s_nxt.q_be;
    end
    s_nxt.ready = (s_nxt.st == l1dc_pkg::S_IDLE) && !s_nxt.sb_v;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // several write ports, kept apart by the collision arbiter
  always_ff @(posedge core_clk) begin
    if (g_tst && s_r.tst_cmd[l1dc_pkg::TC_WR]) begin
      if (s_r.tst_cmd[l1dc_pkg::TC_TAG]) begin
        tag_mem[t_idx] <= s_r.tst_data[31:TAG_LO];
      end else begin
        data_mem[didx(t_bank, t_way, t_set, t_wd)] <= s_r.tst_data;
      end
    end
    if (g_sb) begin
      data_mem[didx(s_r.sb_bank, s_r.sb_way, s_r.sb_set, s_r.sb_wd)] <=
        merge_be(data_mem[didx(s_r.sb_bank, s_r.sb_way, s_r.sb_set, s_r.sb_wd)],
                 s_r.sb_data, s_r.sb_be);
    end
    if (g_fill) begin
      data_mem[didx(s_r.f_bank, s_r.f_way, s_r.f_set, s_r.f_cnt)] <= fill_word;
    end
    if (fill_done) begin
      tag_mem[lidx(s_r.f_bank, s_r.f_way, s_r.f_set)] <= s_r.f_tag;
    end
  end

  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign core_req_ready = s_r.ready;
  assign core_rsp_valid = s_r.rsp_valid;
  assign core_rsp_rdata = s_r.rsp_data;
  assign sys_req_valid  = s_r.sys_valid;
  assign sys_req_write  = s_r.sys_write;
  assign sys_req_burst  = s_r.sys_burst;
  assign sys_req_addr   = s_r.sys_addr;
  assign sys_req_wdata  = s_r.sys_wdata;
  assign sys_req_be     = s_r.sys_be;
endmodule
`default_nettype wire

// ### shared/l1dc_pkg.sv
// constants, encodings and state type of the level-one data cache controller
// Overview of operation
// - each data bank is a two-way set associative cache.
// - the second cache bank adds sets, never ways; associativity stays two.
// - steer select picks address bit 14 or bit 23 to choose the bank.
// - steering applies only while both banks are cache.
// - both banks are cache only when the config field equals binary 11.
// - steer clear: bit 14 one goes to bank A, zero to bank B.
// - steer clear: behaves as one 32K two-way cache.
// - steer set: bit 23 zero goes to bank B, one to bank A.
// - the non-steering bit of 14 and 23 is kept and compared in the tag.
// - steer set: each bank is an independent 16K two-way cache.
// - collision only for same 4K sub-bank, same half bank, same bank.
// - on collision: test access first, then store buffer, then fill traffic.
// - three page write modes: write-through read-alloc, write-through all-alloc, write-back.
// - cache only descriptor-cacheable pages; descriptors disabled means nothing cached.
// - compare tags; hits served locally, misses sent to the system interface.
// - each line is invalid, valid-clean or valid-dirty.
// - a clean victim is overwritten, a dirty victim is copied back first.
// - victim buffer and line-fill buffer hold outgoing and incoming lines.
// - fills start at the requested word, which is forwarded while filling.
// - a cacheable prefetch or allocating store miss stalls the core at least four cycles.
// - later hits complete while the line fill proceeds.
// - an interrupt may abort a stalled load; the issued fill goes on.
// - the outstanding fill completes before another miss to that bank.
// - write-through stores start an external write with the cache update.
// - write-back defers external writes until the line is evicted.
package l1dc_pkg;
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_TCMD   = 12'h004;
  localparam logic [11:0] OFS_TDATA  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam int CTRL_DMC_LO = 0;
  localparam int CTRL_CACHE_BANK_STEER_SELECT   = 4;
  localparam int CTRL_DPE    = 12;
  localparam logic [1:0] DMC_BOTH = 2'h3;
  localparam int STEER_LO_BIT = 14;
  localparam int STEER_HI_BIT = 23;
  localparam logic [1:0] KIND_LOAD  = 2'h0;
  localparam logic [1:0] KIND_STORE = 2'h1;
  localparam logic [1:0] KIND_PREF  = 2'h2;
  localparam logic [1:0] WM_WT_RO = 2'h0;
  localparam logic [1:0] WM_WT_RW = 2'h1;
  localparam logic [1:0] WM_WB    = 2'h2;
  localparam int TC_WR      = 0;
  localparam int TC_TAG     = 1;
  localparam int TC_BANK    = 2;
  localparam int TC_WAY     = 3;
  localparam int TC_WORD_LO = 4;
  localparam int TC_SET_LO  = 8;
  localparam int TD_VALID   = 0;
  localparam int TD_DIRTY   = 1;
  localparam int COLL_BITS  = 3;
  localparam logic [2:0] MISS_STALL_CYC = 3'h4;
  typedef enum logic [2:0] {S_IDLE, S_LOOK, S_CB, S_FREQ, S_WAIT, S_STALL, S_SYS, S_NCW}
    ctl_state_t;
endpackage

// ### tb/l1dc_monitor.sv
// assertion checker bound to the data cache controller ports
`timescale 1ns/1ps
`default_nettype none
module l1dc_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        core_req_valid,
  input wire logic [1:0]  core_req_kind,
  input wire logic [31:0] core_req_addr,
  input wire logic [1:0]  core_req_wmode,
  input wire logic        core_req_ready,
  input wire logic        core_rsp_valid,
  input wire logic        core_abort,
  input wire logic        sys_req_valid,
  input wire logic        sys_req_write,
  input wire logic        sys_req_burst,
  input wire logic [31:0] sys_req_addr,
  input wire logic        sys_req_ready
);
  logic [1:0]  kind_r;
  logic [31:0] addr_r;
  wire logic   take;
  assign take = core_req_valid && core_req_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // kind and address of the last taken request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_r <= 2'h0;
      addr_r <= 32'h0;
    end else if (take) begin
      kind_r <= core_req_kind;
      addr_r <= core_req_addr;
    end
  end
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_take_drops: assert property (take |=> !core_req_ready && !core_rsp_valid)
    else $error("ready or answer after take");
  a_rsp_pulse: assert property (core_rsp_valid |=> !core_rsp_valid)
    else $error("answer longer than one cycle");
  a_load_answers: assert property (take && core_req_kind == l1dc_pkg::KIND_LOAD
    |-> ##[2:80] (core_rsp_valid || core_abort)) else $error("load never answered");
  a_sys_holds: assert property (sys_req_valid && !sys_req_ready
    |=> sys_req_valid && $stable(sys_req_addr) && $stable(sys_req_write))
    else $error("request changed before accept");
  a_burst_reads: assert property (sys_req_valid && sys_req_burst
    |-> !sys_req_write && sys_req_addr[1:0] == 2'h0) else $error("bad fill request");
  a_wt_write: assert property (take && core_req_kind == l1dc_pkg::KIND_STORE
    && core_req_wmode != l1dc_pkg::WM_WB |-> ##[1:80] (sys_req_valid && sys_req_write
    && sys_req_addr[31:2] == addr_r[31:2])) else $error("store not written through");
  a_store_stall: assert property (sys_req_valid && sys_req_ready && sys_req_burst
    && kind_r != l1dc_pkg::KIND_LOAD |=> !core_req_ready [*4]) else $error("miss stall short");
  c_fill: cover property (sys_req_valid && sys_req_ready && sys_req_burst);
  c_write: cover property (sys_req_valid && sys_req_ready && sys_req_write);
  c_answer: cover property (core_rsp_valid);
endmodule
bind l1_data_cache_controller l1dc_monitor mon (.*);
`default_nettype wire

// ### tb/sys_mem_model.sv
// next memory level model: every word reads back its own address
`timescale 1ns/1ps
`default_nettype none
module sys_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sys_req_valid,
  input  wire logic        sys_req_write,
  input  wire logic        sys_req_burst,
  input  wire logic [31:0] sys_req_addr,
  output logic             sys_req_ready,
  output logic             sys_rdata_valid,
  output logic      [31:0] sys_rdata
);
  logic [3:0]  left_r;
  logic [31:0] addr_r;
  logic        slow_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 4'h0;
      addr_r <= 32'h0;
      slow_r <= 1'b0;
      sys_req_ready <= 1'b0;
      sys_rdata_valid <= 1'b0;
      sys_rdata <= 32'h0;
    end else begin
      slow_r <= ~slow_r;
      // alternate prompt and late acceptance
      sys_req_ready <= sys_req_valid && !sys_req_ready && left_r == 4'h0 && slow_r;
      sys_rdata_valid <= left_r != 4'h0;
      // idle data keeps moving so a stale read cannot pass
      sys_rdata <= (left_r != 4'h0) ? addr_r : ~sys_rdata;
      if (left_r != 4'h0) begin
        addr_r[4:2] <= addr_r[4:2] + 3'h1;
        left_r <= left_r - 4'h1;
      end
      if (sys_req_valid && sys_req_ready && !sys_req_write) begin
        left_r <= sys_req_burst ? 4'h8 : 4'h1;
        addr_r <= sys_req_addr;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/l1_data_cache_controller_tb.sv
// self-checking bench for the data cache controller
`timescale 1ns/1ps
`default_nettype none
module l1_data_cache_controller_tb;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, core_req_addr, core_req_wdata, core_rsp_rdata, rd;
  logic [31:0] sys_req_addr, sys_req_wdata, sys_rdata, wr_addr, wr_data;
  logic [1:0]  core_req_kind, core_req_wmode;
  logic [3:0]  core_req_be, sys_req_be;
  logic        core_req_valid, core_req_cacheable, core_abort, core_req_ready, core_rsp_valid;
  logic        sys_req_valid, sys_req_write, sys_req_burst, sys_req_ready, sys_rdata_valid;
  int          mismatches, check_count, bursts, writes, cyc;
  l1_data_cache_controller uut (.*);
  sys_mem_model mem (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // one core request; loads wait for the answer, fills drain after
  task automatic op(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d,
                    input logic c, input logic [1:0] m);
    int n;
    core_req_valid <= 1'b1;
    core_req_kind <= k;
    core_req_addr <= a;
    core_req_wdata <= d;
    core_req_cacheable <= c;
    core_req_wmode <= m;
    do @(posedge core_clk); while (core_req_ready !== 1'b1);
    core_req_valid <= 1'b0;
    rd = 32'hx;
    for (n = 0; n < 90 && k == l1dc_pkg::KIND_LOAD; n++) begin
      @(posedge core_clk);
      if (core_rsp_valid === 1'b1) begin
        rd = core_rsp_rdata;
        n = 90;
      end
    end
    repeat (30) @(posedge core_clk);
  endtask
  task automatic t_regs;
    apb(1'b0, l1dc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, l1dc_pkg::OFS_CTRL, (32'(l1dc_pkg::DMC_BOTH) << l1dc_pkg::CTRL_DMC_LO)
        | (32'h1 << l1dc_pkg::CTRL_DPE));
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask
  task automatic t_fill;
    op(l1dc_pkg::KIND_LOAD, 32'h400c, 32'h0, 1'b1, l1dc_pkg::WM_WB);
    chk("critical word", 32'h400c, rd);
    op(l1dc_pkg::KIND_LOAD, 32'h4010, 32'h0, 1'b1, l1dc_pkg::WM_WB);
    chk("hit word", 32'h4010, rd);
    op(l1dc_pkg::KIND_LOAD, 32'h80400c, 32'h0, 1'b1, l1dc_pkg::WM_WB);
    chk("bit 23 fills", 32'h2, 32'(bursts));
    op(l1dc_pkg::KIND_LOAD, 32'h400c, 32'h0, 1'b1, l1dc_pkg::WM_WB);
    chk("second way kept", 32'h2, 32'(bursts));
  endtask
  task automatic t_stores;
    op(l1dc_pkg::KIND_STORE, 32'h4010, 32'hcafe0001, 1'b1, l1dc_pkg::WM_WT_RO);
    chk("through address", 32'h4010, wr_addr);
    chk("through data", 32'hcafe0001, wr_data);
    op(l1dc_pkg::KIND_STORE, 32'h12340, 32'h5a5a0002, 1'b1, l1dc_pkg::WM_WB);
    chk("back writes", 32'h1, 32'(writes));
    op(l1dc_pkg::KIND_LOAD, 32'h12340, 32'h0, 1'b1, l1dc_pkg::WM_WB);
    chk("dirty word", 32'h5a5a0002, rd);
    op(l1dc_pkg::KIND_LOAD, 32'h9000, 32'h0, 1'b0, l1dc_pkg::WM_WB);
    chk("uncached word", 32'h9000, rd);
    chk("uncached fills", 32'h3, 32'(bursts));
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (sys_req_valid && sys_req_ready && sys_req_burst)
      bursts++;
    if (sys_req_valid && sys_req_ready && sys_req_write) begin
      writes++;
      wr_addr = sys_req_addr;
      wr_data = sys_req_wdata;
    end
    if (cyc == 4000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, core_req_valid, core_req_cacheable, core_abort} = 7'h0;
    {paddr, pwdata, core_req_addr, core_req_wdata} = 108'h0;
    {core_req_kind, core_req_wmode} = 4'h0;
    core_req_be = 4'hf;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_fill;
    t_stores;
    stop_test;
  end
endmodule
`default_nettype wire
